// ==== hw/ptc_pkg.sv ====
// Purpose: constants and types of the pulse trigger controller
// Assumes: 100 MHz core clock, APB register access
// Notes: times are in ns, cycle counts derive from them
package ptc_pkg;
    // clock and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_NS = 10;
    localparam int PULSE_NS = 100;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int MON_NS = 50;
    localparam int MON_CYC = (MON_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESTART_NS = 10_000;
    localparam int RESTART_CYC = (RESTART_NS + CLK_NS - 1) / CLK_NS;
    localparam int MEAS_GATE_NS = 1_000_000_000;
    localparam int MEAS_GATE_CYC = MEAS_GATE_NS / CLK_NS;
    // rates and fault code
    localparam logic [31:0] RATE_RST = 32'h0000_03E8;
    localparam logic [31:0] RATE_MAX = 32'h0000_2710;
    localparam logic [31:0] FAULT_RATE = 32'h0000_0BBA;
    // register byte offsets
    localparam logic [7:0] ADDR_RX = 8'h00;
    localparam logic [7:0] ADDR_TX = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_SETPOINT = 8'h0C;
    localparam logic [7:0] ADDR_MEASURED = 8'h10;
    // character codes and buffer sizes
    localparam logic [7:0] CHR_CR = 8'h0D;
    localparam logic [7:0] CHR_LF = 8'h0A;
    localparam logic [7:0] CHR_0 = 8'h30;
    localparam logic [7:0] CHR_9 = 8'h39;
    localparam logic [7:0] CHR_DOT = 8'h2E;
    localparam int LINE_LEN = 16;
    localparam int TX_LEN = 32;
    localparam int ERR_LEN = 13;
    // command and reply texts
    localparam logic [31:0] CMD_SIF = "sif ";
    localparam logic [31:0] CMD_GIF = "gif?";
    localparam logic [31:0] CMD_RLF = "rlf?";
    localparam logic [31:0] CMD_GLT = "glt?";
    localparam logic [15:0] CMD_F = "f?";
    localparam logic [15:0] CMD_CF = "cf";
    localparam logic [95:0] CMD_SLT_INT = "slt internal";
    localparam logic [95:0] CMD_SLT_EXT = "slt external";
    localparam logic [71:0] CMD_SLT_GATE = "slt gated";
    localparam logic [15:0] STR_OK = "OK";
    localparam logic [103:0] STR_ERR = "Syntax error:";
    localparam logic [63:0] STR_INT = "Internal";
    localparam logic [63:0] STR_EXT = "External";
    localparam logic [39:0] STR_GATE = "Gated";
    // modes, parser states, bus carriers
    typedef enum logic [1:0] {TRIG_INT, TRIG_EXT, TRIG_GATE} ptc_mode_type;
    typedef enum logic {CS_IDLE, CS_CONV} ptc_cmd_state_type;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ptc_apb_req_type;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ptc_apb_rsp_type;
endpackage

// ==== hw/ptc_top.sv ====
// Purpose: trigger sequencer with ASCII command channel over APB
// Assumes: DETECT_I is synchronous to CORE_CLK_I, TRIG_I is synchronised in two stages
// Notes: host writes command characters, reads reply characters
`timescale 1ns/100ps
module ptc_top
#(
    parameter int GATE_CYC = ptc_pkg::MEAS_GATE_CYC
)
(
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire ptc_pkg::ptc_apb_req_type APB_REQ_I,
    output ptc_pkg::ptc_apb_rsp_type APB_RSP_O,
    input wire logic TRIG_I,
    input wire logic DETECT_I,
    output logic PULSE_O,
    output logic MON_O
);
    ////////////////////////////////////////////////////////////////////
    // shared state
    ptc_pkg::ptc_mode_type mode, next_mode;
    logic [31:0] setpoint, next_setpoint;
    logic restart_req, next_restart_req;
    logic clear_req, next_clear_req;
    logic [31:0] measured, next_measured;
    logic fault, next_fault;

    ////////////////////////////////////////////////////////////////////
    // trigger generation, pulse shaping and rate measurement
    logic trig_s1, trig_s2, trig_s3;
    logic det_d;
    logic [31:0] acc, next_acc, step, next_step;
    logic [9:0] restart_cnt, next_restart_cnt;
    logic [3:0] pulse_cnt, next_pulse_cnt, mon_cnt, next_mon_cnt;
    logic next_pulse, next_mon;
    logic [31:0] gate_cnt, next_gate_cnt, tally, next_tally;
    logic [32:0] sum;
    logic tick, event_hit, fire, hold;

    // next values of the trigger path
    always_comb
    begin
        sum = {1'b0, acc} + {1'b0, step};
        tick = 1'b0;
        next_acc = sum[31:0];
        next_step = step;
        if (sum >= 33'(ptc_pkg::CLK_HZ))
        begin
            next_acc = 32'(sum - 33'(ptc_pkg::CLK_HZ));
            next_step = setpoint;
            tick = 1'b1;
        end
        unique case (mode)
            ptc_pkg::TRIG_INT: event_hit = tick;
            ptc_pkg::TRIG_EXT: event_hit = trig_s2 & ~trig_s3;
            ptc_pkg::TRIG_GATE: event_hit = tick & trig_s2;
            default: event_hit = 1'b0;
        endcase
        hold = restart_req || (restart_cnt != 10'h000)
            || (mode == ptc_pkg::TRIG_GATE && !trig_s2);
        next_restart_cnt = (restart_cnt == 10'h000) ? 10'h000
            : restart_cnt - 10'h001;
        if (restart_req)
        begin
            next_restart_cnt = 10'(ptc_pkg::RESTART_CYC);
        end
        if (hold)
        begin
            next_acc = 32'h0000_0000;
            next_step = setpoint;
            event_hit = 1'b0;
        end
        fire = event_hit && (pulse_cnt == 4'h0);
        next_pulse_cnt = (pulse_cnt == 4'h0) ? 4'h0 : pulse_cnt - 4'h1;
        if (fire)
        begin
            next_pulse_cnt = 4'(ptc_pkg::PULSE_CYC);
        end
        next_pulse = (next_pulse_cnt != 4'h0);
        next_mon_cnt = (mon_cnt == 4'h0) ? 4'h0 : mon_cnt - 4'h1;
        if (DETECT_I && !det_d)
        begin
            next_mon_cnt = 4'(ptc_pkg::MON_CYC);
        end
        next_mon = (next_mon_cnt != 4'h0);
        next_gate_cnt = gate_cnt + 32'h0000_0001;
        next_tally = tally + {31'h0, fire};
        next_measured = measured;
        next_fault = fault && !clear_req;
        if (gate_cnt == 32'(GATE_CYC - 1))
        begin
            next_gate_cnt = 32'h0000_0000;
            next_measured = next_tally;
            next_tally = 32'h0000_0000;
            if (next_measured > ptc_pkg::RATE_MAX)
            begin
                next_fault = 1'b1;
            end
        end
    end

    // registers of the trigger path
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            det_d <= 1'b0;
            acc <= 32'h0000_0000;
            step <= ptc_pkg::RATE_RST;
            restart_cnt <= 10'h000;
            pulse_cnt <= 4'h0;
            mon_cnt <= 4'h0;
            PULSE_O <= 1'b0;
            MON_O <= 1'b0;
            gate_cnt <= 32'h0000_0000;
            tally <= 32'h0000_0000;
            measured <= 32'h0000_0000;
            fault <= 1'b0;
        end
        else
        begin
            trig_s1 <= TRIG_I;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            det_d <= DETECT_I;
            acc <= next_acc;
            step <= next_step;
            restart_cnt <= next_restart_cnt;
            pulse_cnt <= next_pulse_cnt;
            mon_cnt <= next_mon_cnt;
            PULSE_O <= next_pulse;
            MON_O <= next_mon;
            gate_cnt <= next_gate_cnt;
            tally <= next_tally;
            measured <= next_measured;
            fault <= next_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command channel: line capture, parsing, reply and APB slave
    ptc_pkg::ptc_cmd_state_type state, next_state;
    logic [127:0] line_vec, next_line_vec;
    logic [4:0] line_len, next_line_len;
    logic line_ovf, next_line_ovf, cr_seen, next_cr_seen;
    logic line_done, next_line_done, num_bad, next_num_bad;
    logic [31:0] num_acc, next_num_acc, conv, next_conv;
    logic [7:0] tx_buf [ptc_pkg::TX_LEN];
    logic [7:0] next_tx_buf [ptc_pkg::TX_LEN];
    logic [5:0] tx_rd, next_tx_rd, tx_len, next_tx_len;
    logic [4:0] wr_pos, next_wr_pos;
    ptc_pkg::ptc_apb_rsp_type next_rsp;
    logic tx_avail, setup, wr_acc, rd_acc;
    logic [7:0] ch;
    logic [103:0] str_val;
    logic [4:0] str_n;
    logic str_go, num_go, frac;
    logic [31:0] num_val;

    // next values of the command channel
    always_comb
    begin
        next_state = state;
        next_line_vec = line_vec;
        next_line_len = line_len;
        next_line_ovf = line_ovf;
        next_cr_seen = cr_seen;
        next_line_done = line_done;
        next_num_bad = num_bad;
        next_num_acc = num_acc;
        next_conv = conv;
        next_tx_buf = tx_buf;
        next_tx_rd = tx_rd;
        next_tx_len = tx_len;
        next_wr_pos = wr_pos;
        next_mode = mode;
        next_setpoint = setpoint;
        next_restart_req = 1'b0;
        next_clear_req = 1'b0;
        str_val = 104'h0;
        str_n = 5'h00;
        str_go = 1'b0;
        num_go = 1'b0;
        frac = 1'b0;
        num_val = 32'h0000_0000;
        tx_avail = (tx_rd < tx_len);
        ch = APB_REQ_I.pwdata[7:0];
        setup = APB_REQ_I.psel && !APB_REQ_I.penable;
        wr_acc = APB_REQ_I.psel && APB_REQ_I.penable && APB_RSP_O.pready
            && APB_REQ_I.pwrite;
        rd_acc = APB_REQ_I.psel && APB_REQ_I.penable && APB_RSP_O.pready
            && !APB_REQ_I.pwrite;
        // bus answer prepared in the setup cycle, zero wait states
        next_rsp.pready = setup;
        next_rsp.pslverr = 1'b0;
        next_rsp.prdata = 32'h0000_0000;
        if (setup)
        begin
            case (APB_REQ_I.paddr)
                ptc_pkg::ADDR_RX: next_rsp.prdata = 32'h0000_0000;
                ptc_pkg::ADDR_TX: next_rsp.prdata = {23'h0, tx_avail,
                    tx_avail ? tx_buf[tx_rd[4:0]] : 8'h00};
                ptc_pkg::ADDR_STATUS: next_rsp.prdata = {27'h0,
                    line_done || state != ptc_pkg::CS_IDLE, tx_avail,
                    fault, mode};
                ptc_pkg::ADDR_SETPOINT: next_rsp.prdata = setpoint;
                ptc_pkg::ADDR_MEASURED: next_rsp.prdata = measured;
                default: next_rsp.pslverr = 1'b1;
            endcase
        end
        // pop only a character that the read actually carried
        if (rd_acc && APB_REQ_I.paddr == ptc_pkg::ADDR_TX
            && APB_RSP_O.prdata[8])
        begin
            next_tx_rd = tx_rd + 6'h01;
        end
        // command character from the host
        if (wr_acc && APB_REQ_I.paddr == ptc_pkg::ADDR_RX && !line_done)
        begin
            if (cr_seen && ch == ptc_pkg::CHR_LF)
            begin
                next_line_done = 1'b1;
            end
            else if (ch == ptc_pkg::CHR_CR)
            begin
                next_cr_seen = 1'b1;
            end
            else
            begin
                next_cr_seen = 1'b0;
                if (line_len == 5'(ptc_pkg::LINE_LEN))
                begin
                    next_line_ovf = 1'b1;
                end
                else
                begin
                    next_line_vec = {line_vec[119:0], ch};
                    next_line_len = line_len + 5'h01;
                end
                if (line_len >= 5'h04)
                begin
                    if (ch >= ptc_pkg::CHR_0 && ch <= ptc_pkg::CHR_9)
                    begin
                        next_num_acc = 32'(num_acc * 32'h0000_000A
                            + {24'h0, ch - ptc_pkg::CHR_0});
                    end
                    else
                    begin
                        next_num_bad = 1'b1;
                    end
                end
            end
        end
        // decode a complete line once the previous reply is drained
        if (state == ptc_pkg::CS_IDLE && line_done && !tx_avail)
        begin
            next_line_done = 1'b0;
            next_line_len = 5'h00;
            next_line_vec = 128'h0;
            next_line_ovf = 1'b0;
            next_cr_seen = 1'b0;
            next_num_acc = 32'h0000_0000;
            next_num_bad = 1'b0;
            str_go = 1'b1;
            str_val = 104'(ptc_pkg::STR_OK);
            str_n = 5'h02;
            if (line_ovf)
            begin
                str_n = 5'h00;
            end
            else if (line_len >= 5'h05 && !num_bad
                && line_vec[8 * line_len - 1 -: 32] == ptc_pkg::CMD_SIF)
            begin
                next_setpoint = num_acc;
            end
            else if (line_len == 5'h04 && line_vec[31:0] == ptc_pkg::CMD_GIF)
            begin
                num_go = 1'b1;
                num_val = setpoint;
            end
            else if (line_len == 5'h04 && line_vec[31:0] == ptc_pkg::CMD_RLF)
            begin
                num_go = 1'b1;
                num_val = measured;
                frac = 1'b1;
            end
            else if (line_len == 5'h0C
                && line_vec[95:0] == ptc_pkg::CMD_SLT_INT)
            begin
                next_mode = ptc_pkg::TRIG_INT;
            end
            else if (line_len == 5'h0C
                && line_vec[95:0] == ptc_pkg::CMD_SLT_EXT)
            begin
                next_mode = ptc_pkg::TRIG_EXT;
            end
            else if (line_len == 5'h09
                && line_vec[71:0] == ptc_pkg::CMD_SLT_GATE)
            begin
                next_mode = ptc_pkg::TRIG_GATE;
            end
            else if (line_len == 5'h04 && line_vec[31:0] == ptc_pkg::CMD_GLT)
            begin
                str_val = (mode == ptc_pkg::TRIG_INT)
                    ? 104'(ptc_pkg::STR_INT)
                    : (mode == ptc_pkg::TRIG_EXT) ? 104'(ptc_pkg::STR_EXT)
                    : 104'(ptc_pkg::STR_GATE);
                str_n = (mode == ptc_pkg::TRIG_GATE) ? 5'h05 : 5'h08;
            end
            else if (line_len == 5'h02 && line_vec[15:0] == ptc_pkg::CMD_F)
            begin
                num_go = 1'b1;
                num_val = fault ? ptc_pkg::FAULT_RATE : 32'h0000_0000;
            end
            else if (line_len == 5'h02 && line_vec[15:0] == ptc_pkg::CMD_CF)
            begin
                next_clear_req = 1'b1;
            end
            else
            begin
                str_n = 5'h00;
            end
            next_restart_req = (next_mode != mode);
            if (num_go)
            begin
                str_go = 1'b0;
                next_state = ptc_pkg::CS_CONV;
                next_conv = num_val;
                next_tx_buf[ptc_pkg::TX_LEN - 1] = ptc_pkg::CHR_CR;
                next_tx_buf[ptc_pkg::TX_LEN - 2] = ptc_pkg::CHR_0;
                next_tx_buf[ptc_pkg::TX_LEN - 3] = ptc_pkg::CHR_DOT;
                next_wr_pos = frac ? 5'h1C : 5'h1E;
                next_tx_len = 6'(ptc_pkg::TX_LEN);
                next_tx_rd = 6'(ptc_pkg::TX_LEN);
            end
            else if (str_n == 5'h00)
            begin
                // error prefix, then the offending line
                str_go = 1'b0;
                for (int k = 0; k < ptc_pkg::ERR_LEN; k++)
                begin
                    next_tx_buf[k] =
                        ptc_pkg::STR_ERR[8 * (ptc_pkg::ERR_LEN - 1 - k) +: 8];
                end
                for (int k = 0; k < ptc_pkg::LINE_LEN; k++)
                begin
                    if (k < int'(line_len))
                    begin
                        next_tx_buf[ptc_pkg::ERR_LEN + k] =
                            line_vec[8 * (int'(line_len) - 1 - k) +: 8];
                    end
                end
                next_tx_buf[5'(ptc_pkg::ERR_LEN) + line_len] =
                    ptc_pkg::CHR_CR;
                next_tx_rd = 6'h00;
                next_tx_len = 6'(ptc_pkg::ERR_LEN) + {1'b0, line_len}
                    + 6'h01;
            end
        end
        // plain text replies
        if (str_go)
        begin
            for (int k = 0; k < ptc_pkg::ERR_LEN; k++)
            begin
                if (k < int'(str_n))
                begin
                    next_tx_buf[k] = str_val[8 * (int'(str_n) - 1 - k) +: 8];
                end
            end
            next_tx_buf[str_n] = ptc_pkg::CHR_CR;
            next_tx_rd = 6'h00;
            next_tx_len = {1'b0, str_n} + 6'h01;
        end
        // decimal digits written from the tail downwards
        if (state == ptc_pkg::CS_CONV)
        begin
            next_tx_buf[wr_pos] = 8'(conv % 32'h0000_000A) + ptc_pkg::CHR_0;
            next_conv = conv / 32'h0000_000A;
            next_wr_pos = wr_pos - 5'h01;
            if (conv < 32'h0000_000A)
            begin
                next_tx_rd = {1'b0, wr_pos};
                next_state = ptc_pkg::CS_IDLE;
            end
        end
    end

    // registers of the command channel
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            state <= ptc_pkg::CS_IDLE;
            line_vec <= 128'h0;
            line_len <= 5'h00;
            line_ovf <= 1'b0;
            cr_seen <= 1'b0;
            line_done <= 1'b0;
            num_bad <= 1'b0;
            num_acc <= 32'h0000_0000;
            conv <= 32'h0000_0000;
            tx_buf <= '{default: 8'h00};
            tx_rd <= 6'h00;
            tx_len <= 6'h00;
            wr_pos <= 5'h00;
            mode <= ptc_pkg::TRIG_INT;
            setpoint <= ptc_pkg::RATE_RST;
            restart_req <= 1'b0;
            clear_req <= 1'b0;
            APB_RSP_O <= '0;
        end
        else
        begin
            state <= next_state;
            line_vec <= next_line_vec;
            line_len <= next_line_len;
            line_ovf <= next_line_ovf;
            cr_seen <= next_cr_seen;
            line_done <= next_line_done;
            num_bad <= next_num_bad;
            num_acc <= next_num_acc;
            conv <= next_conv;
            tx_buf <= next_tx_buf;
            tx_rd <= next_tx_rd;
            tx_len <= next_tx_len;
            wr_pos <= next_wr_pos;
            mode <= next_mode;
            setpoint <= next_setpoint;
            restart_req <= next_restart_req;
            clear_req <= next_clear_req;
            APB_RSP_O <= next_rsp;
        end
    end
endmodule // ptc_top

// ==== dv/ptc_checker.sv ====
// Purpose: port assertions for the pulse trigger controller
// Assumes: bound to ptc_top, one clock domain
// Notes: bus timing, pulse shape and monitor shape
`timescale 1ns/100ps
module ptc_checker
#(
    parameter int GATE_CYC = 1000
)
(
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire ptc_pkg::ptc_apb_req_type APB_REQ_I,
    input wire ptc_pkg::ptc_apb_rsp_type APB_RSP_O,
    input wire logic TRIG_I,
    input wire logic DETECT_I,
    input wire logic PULSE_O,
    input wire logic MON_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);
    ////////////////////////////////////////////////////////////////////////
    // bus answers: zero wait, one cycle, only in access
    a_ready_zero_wait: assert property (APB_REQ_I.psel &&
        !APB_REQ_I.penable |=> APB_RSP_O.pready)
        else $error("no ready in first access cycle");
    a_ready_in_access: assert property (APB_RSP_O.pready |->
        APB_REQ_I.psel && APB_REQ_I.penable)
        else $error("ready outside access phase");
    a_ready_one_cycle: assert property (APB_RSP_O.pready |=>
        !APB_RSP_O.pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (APB_RSP_O.pslverr |->
        APB_RSP_O.pready)
        else $error("error without ready");
    a_quiet_after_reset: assert property ($fell(RST_I) |->
        !PULSE_O && !MON_O && !APB_RSP_O.pready)
        else $error("outputs active after reset");
    ////////////////////////////////////////////////////////////////////////
    // emitter pulse and monitor shape
    a_pulse_width: assert property ($rose(PULSE_O) |->
        PULSE_O[*8] ##1 PULSE_O[*2] ##1 !PULSE_O)
        else $error("emitter pulse not ten cycles");
    a_mon_shape: assert property ($rose(DETECT_I) |=>
        MON_O[*5] ##1 !MON_O)
        else $error("monitor pulse not five cycles");
    a_mon_cause: assert property ($rose(MON_O) |->
        $past(DETECT_I) && !$past(DETECT_I, 2))
        else $error("monitor pulse without detection");
    // main scenarios reached
    c_pulse: cover property ($rose(PULSE_O));
    c_mon: cover property ($rose(MON_O));
    c_err: cover property (APB_RSP_O.pslverr);
endmodule // ptc_checker

// ==== dv/ptc_emitter_model.sv ====
// Purpose: emitter and detector in front of the controller
// Assumes: detector sees light two cycles after drive
// Notes: one detection per emitted pulse
`timescale 1ns/100ps
module ptc_emitter_model
(
    input wire logic clk_i,
    input wire logic pulse_i,
    output logic detect_o
);
    logic [1:0] delay = 2'h0;
    // optical delay line of the emitter
    always_ff @(posedge clk_i)
    begin
        delay <= {delay[0], pulse_i};
    end
    assign detect_o = delay[1];
endmodule // ptc_emitter_model

// ==== dv/pulse_trigger_controller_tb.sv ====
// Purpose: self-checking bench for the pulse trigger controller
// Assumes: measuring gate shortened to 1000 cycles
// Notes: commands travel as characters through the bus registers
`timescale 1ns/100ps
module pulse_trigger_controller_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic trig = 1'b0;
    logic detect;
    logic pulse;
    logic mon;
    ptc_pkg::ptc_apb_req_type req = '0;
    ptc_pkg::ptc_apb_rsp_type rsp;
    int mismatches = 0;
    int check_count = 0;
    int pulses = 0;
    logic [31:0] rd;
    logic err;
    ptc_top #(.GATE_CYC(1000)) uut (.CORE_CLK_I(clk), .RST_I(rst),
        .APB_REQ_I(req), .APB_RSP_O(rsp), .TRIG_I(trig),
        .DETECT_I(detect), .PULSE_O(pulse), .MON_O(mon));
    ptc_emitter_model emitter (.clk_i(clk), .pulse_i(pulse),
        .detect_o(detect));
    // clock and pulse counter
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge pulse) pulses++;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic lost();
        mismatches++;
        $display("unexpected at %0t: wait ran out", $time);
        conclude();
    endtask
    // one bus transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (n >= 50)
            lost();
    endtask
    // send a command line, collect the reply up to carriage return
    task automatic cmd(input string s, input logic [255:0] exp);
        logic [255:0] r;
        bit done;
        string t;
        r = '0;
        done = 0;
        t = {s, "\r\n"};
        for (int i = 0; i < t.len(); i++)
            apb(1'b1, ptc_pkg::ADDR_RX, {24'h000000, t[i]});
        for (int n = 0; n < 3000 && !done; n++)
        begin
            apb(1'b0, ptc_pkg::ADDR_TX, 32'h0);
            if (rd[8] === 1'b1)
            begin
                r = {r[247:0], rd[7:0]};
                done = (rd[7:0] === 8'h0D);
            end
        end
        if (!done)
            lost();
        check(r, exp);
        apb(1'b0, ptc_pkg::ADDR_TX, 32'h0);
        check(rd[8], 1'b0);
    endtask
    task automatic expect_pulses(input int n, input int lo, input int hi);
        int p0;
        p0 = pulses;
        repeat (n) @(posedge clk);
        check(pulses - p0 >= lo && pulses - p0 <= hi, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        apb(1'b0, ptc_pkg::ADDR_STATUS, 32'h0);
        check(rd[2:0], 3'h0);
        apb(1'b0, ptc_pkg::ADDR_SETPOINT, 32'h0);
        check(rd, 32'h000003E8);
        cmd("gif?", "1000\r");
        cmd("glt?", "Internal\r");
        cmd("f?", "0\r");
        cmd("cf", "OK\r");
        apb(1'b0, 8'h14, 32'h0);
        check({err, rd}, 33'h100000000);
        $display("test defaults done");
    endtask
    task automatic t_parser();
        cmd("sif 1000000", "OK\r");
        cmd("gif?", "1000000\r");
        cmd("Sif 5", "Syntax error:Sif 5\r");
        cmd("sif  5", "Syntax error:sif  5\r");
        cmd("sif 12345678901234", "Syntax error:sif 123456789012\r");
        apb(1'b0, ptc_pkg::ADDR_SETPOINT, 32'h0);
        check(rd, 32'h000F4240);
        $display("test parser done");
    endtask
    task automatic t_modes();
        string nm[3] = '{"external", "gated", "internal"};
        logic [255:0] gl[3] = '{"External\r", "Gated\r", "Internal\r"};
        for (int m = 0; m < 3; m++)
        begin
            cmd({"slt ", nm[m]}, "OK\r");
            cmd("glt?", gl[m]);
            apb(1'b0, ptc_pkg::ADDR_STATUS, 32'h0);
            check(rd[1:0], (m + 1) % 3);
        end
        $display("test modes done");
    endtask
    task automatic t_measure();
        expect_pulses(3200, 20, 32);
        expect_pulses(1000, 10, 10);
        apb(1'b0, ptc_pkg::ADDR_MEASURED, 32'h0);
        check(rd, 32'h0000000A);
        cmd("rlf?", "10.0\r");
        $display("test measure done");
    endtask
    task automatic t_external();
        cmd("slt external", "OK\r");
        trig <= 1'b1;
        expect_pulses(1100, 0, 0);
        trig <= 1'b0;
        expect_pulses(20, 0, 0);
        trig <= 1'b1;
        expect_pulses(40, 1, 1);
        trig <= 1'b0;
        expect_pulses(20, 0, 0);
        trig <= 1'b1;
        expect_pulses(40, 1, 1);
        trig <= 1'b0;
        $display("test external done");
    endtask
    task automatic t_gated();
        cmd("slt gated", "OK\r");
        expect_pulses(1100, 0, 0);
        trig <= 1'b1;
        expect_pulses(1000, 9, 10);
        trig <= 1'b0;
        repeat (5) @(posedge clk);
        expect_pulses(500, 0, 0);
        trig <= 1'b1;
        cmd("slt internal", "OK\r");
        expect_pulses(800, 0, 0);
        trig <= 1'b0;
        $display("test gated done");
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_parser();
        t_modes();
        t_measure();
        t_external();
        t_gated();
        conclude();
    end
endmodule // pulse_trigger_controller_tb
bind ptc_top ptc_checker #(.GATE_CYC(GATE_CYC)) chk (.CORE_CLK_I(CORE_CLK_I),
    .RST_I(RST_I), .APB_REQ_I(APB_REQ_I), .APB_RSP_O(APB_RSP_O),
    .TRIG_I(TRIG_I), .DETECT_I(DETECT_I), .PULSE_O(PULSE_O), .MON_O(MON_O));
